// *** src/mcs_seq.sv ***
// mcs_seq: decode-stage microcode routing, sequencing and alignment checks
// assumes fetch holds IN_VALID/IN_INSTR until IN_READY; issue side
// returns DEP_DONE once the prior microword result is available
//
// Functional notes
// - the first microword leaves the ROM no sooner than 11 cycles after routing.
// - complex or resource-hungry instructions are replaced by simpler microwords.
// - typical expansions give two or three ops, integer then load/store, dependent.
// - a microword depending on an earlier one is stalled at issue until resolved.
// - only block- or segment-crossing loads/stores go to microcode conditionally; aligned ones without seg_cross run direct.
// - a microcoded instruction is atomic; async interrupts wait for its end.
// - load-string and other heavy instructions are always microcoded.
// - byte-reversed loads/stores get exactly the normal alignment treatment.
// - non-microcode cache-inhibited 1/2/4/8 byte access: aligned runs, else interrupt.
// - a cache-inhibited access from inside microcode always raises alignment.
`timescale 1ns/10ps
module mcs_seq #(
	parameter int unsigned ROM_WAIT = mcs_pkg::ROM_MIN_CYC
) (
	input  wire logic                CLK,
	input  wire logic                RST_N,
	input  wire logic                IN_VALID,
	input  mcs_pkg::mcs_instr_t      IN_INSTR,
	output logic                     IN_READY,
	output logic                     DIRECT_VALID,
	output mcs_pkg::mcs_instr_t      DIRECT_INSTR,
	output logic                     UOP_VALID,
	output mcs_pkg::mcs_uword_t      UOP_WORD,
	output logic                     UOP_CI_ALIGN,
	input  wire logic                ISSUE_READY,
	input  wire logic                DEP_DONE,
	output logic                     ALIGN_INT,
	output logic                     MICROCODED_MARKER,
	input  wire logic                ASYNC_IRQ_REQ,
	output logic                     ASYNC_IRQ_TAKE
);
	import mcs_pkg::*;

	initial begin
		if (ROM_WAIT < ROM_MIN_CYC || ROM_WAIT > 255)
			$error("mcs_seq: ROM_WAIT out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// alignment helpers

	function automatic logic nat_aligned(input logic [ADDR_W-1:0] ea,
		input logic [3:0] sz);
		logic r;
		r = 1'b0;
		case (sz)
			4'h1: r = 1'b1;
			4'h2: r = ea[0] == 1'b0;
			4'h4: r = ea[1:0] == 2'b00;
			4'h8: r = ea[2:0] == 3'b000;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// set when the end address leaves the start address's 32-byte block
	function automatic logic crosses(input logic [ADDR_W-1:0] ea,
		input logic [3:0] sz);
		logic [16:0] lo;
		logic [16:0] hi;
		logic        r;
		lo = {1'b0, ea[15:0]};
		hi = lo + {13'h0000, sz} - 17'h00001;
		r = 1'b0;
		if (sz != 4'h0) begin
			r = (lo[16:5] != hi[16:5]) || (lo[16:12] != hi[16:12])
				|| (lo[16] != hi[16]);
		end
		return r;
	endfunction

	function automatic logic is_ldst(input mcs_op_t op);
		return op == MCS_OP_LOAD || op == MCS_OP_STORE
			|| op == MCS_OP_FLD || op == MCS_OP_FST;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// classification of the incoming instruction

	logic in_fp;
	logic in_int;
	logic cls_align;
	logic cls_mc;

	always_comb begin
		// byte-reverse bit deliberately ignored
		in_fp  = IN_INSTR.op == MCS_OP_FLD || IN_INSTR.op == MCS_OP_FST;
		in_int = IN_INSTR.op == MCS_OP_LOAD || IN_INSTR.op == MCS_OP_STORE;
		cls_align = 1'b0;
		cls_mc    = 1'b0;
		if (in_fp && IN_INSTR.ea[1:0] != 2'b00) begin
			cls_align = 1'b1;
		end else if (IN_INSTR.cinh && is_ldst(IN_INSTR.op)) begin
			cls_align = !nat_aligned(IN_INSTR.ea, IN_INSTR.size);
		end else if ((in_int || in_fp) && (IN_INSTR.seg_cross
			|| crosses(IN_INSTR.ea, IN_INSTR.size))) begin
			cls_mc = 1'b1;
		end
		// aligned loads/stores without seg_cross fall through to direct
		if (IN_INSTR.op == MCS_OP_HEAVY || IN_INSTR.op == MCS_OP_CPLX) begin
			cls_mc    = 1'b1;
			cls_align = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer state

	mcs_state_t  state_q, state_d;
	logic [7:0]  wait_q, wait_d;
	logic [1:0]  step_q, step_d;
	logic [3:0]  idx_q, idx_d;
	logic        dep_pend_q, dep_pend_d;
	logic        dvalid_q, dvalid_d;
	mcs_instr_t  dinstr_q, dinstr_d;
	logic        aint_q, aint_d;
	logic        rom_ok_q, rom_ok_d;
	mcs_uword_t  rom_word;

	mcs_rom #(
		.DEPTH (ROM_DEPTH),
		.SEQ   (UOP_MAX)
	) u_rom (
		.CLK  (CLK),
		.IDX  (idx_q),
		.STEP (step_q),
		.WORD (rom_word)
	);

	logic busy;
	logic uop_fire;
	logic in_fire;

	assign busy     = state_q != MCS_IDLE;
	assign IN_READY = !busy && (!dvalid_q || ISSUE_READY);
	assign in_fire  = IN_VALID && IN_READY;
	// dependent microword held until prior result returns
	assign UOP_VALID = state_q == MCS_ISSUE && rom_ok_q
		&& !(rom_word.dep_prev && dep_pend_q);
	assign uop_fire  = UOP_VALID && ISSUE_READY;
	assign UOP_WORD  = rom_word;
	// ci access inside a sequence always flags alignment
	assign UOP_CI_ALIGN = UOP_VALID && dinstr_q.cinh
		&& is_ldst(rom_word.op);

	always_comb begin
		state_d    = state_q;
		wait_d     = wait_q;
		step_d     = step_q;
		idx_d      = idx_q;
		dep_pend_d = dep_pend_q;
		rom_ok_d   = 1'b0;
		dvalid_d   = dvalid_q && !ISSUE_READY;
		dinstr_d   = dinstr_q;
		aint_d     = 1'b0;
		case (state_q)
			MCS_IDLE: begin
				if (in_fire) begin
					dinstr_d = IN_INSTR;
					if (cls_align) begin
						aint_d = 1'b1;
					end else if (cls_mc) begin
						// expand into microwords
						state_d    = MCS_WAIT;
						wait_d     = 8'(ROM_WAIT - 2);
						step_d     = 2'h0;
						idx_d      = IN_INSTR.rom_idx;
						dep_pend_d = 1'b0;
					end else begin
						dvalid_d = 1'b1;
					end
				end
			end
			MCS_WAIT: begin
				// rom access latency floor
				if (wait_q == 8'h00) begin
					state_d  = MCS_ISSUE;
					rom_ok_d = 1'b1;
				end else begin
					wait_d = wait_q - 8'h01;
				end
			end
			MCS_ISSUE: begin
				rom_ok_d = 1'b1;
				if (DEP_DONE)
					dep_pend_d = 1'b0;
				if (uop_fire) begin
					dep_pend_d = 1'b1;
					rom_ok_d   = 1'b0;
					if (rom_word.last || step_q == 2'(UOP_MAX - 1)) begin
						state_d  = MCS_IDLE;
						rom_ok_d = 1'b0;
					end else begin
						step_d = step_q + 2'h1;
					end
				end
			end
			default: state_d = MCS_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q    <= MCS_IDLE;
			wait_q     <= 8'h00;
			step_q     <= 2'h0;
			idx_q      <= 4'h0;
			dep_pend_q <= 1'b0;
			rom_ok_q   <= 1'b0;
			dvalid_q   <= 1'b0;
			dinstr_q   <= '0;
			aint_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			wait_q     <= wait_d;
			step_q     <= step_d;
			idx_q      <= idx_d;
			dep_pend_q <= dep_pend_d;
			rom_ok_q   <= rom_ok_d;
			dvalid_q   <= dvalid_d;
			dinstr_q   <= dinstr_d;
			aint_q     <= aint_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign DIRECT_VALID      = dvalid_q;
	assign DIRECT_INSTR      = dinstr_q;
	assign ALIGN_INT         = aint_q;
	assign MICROCODED_MARKER = busy;
	// irq deferred for the whole sequence, costs interrupt latency
	assign ASYNC_IRQ_TAKE    = ASYNC_IRQ_REQ && !busy;

endmodule

// *** pkg/mcs_pkg.sv ***
// mcs_pkg: shared types and constants for the microcode sequencing block
// assumes a single 250 MHz core clock; no software registers
package mcs_pkg;

	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned ROM_MIN_CYC   = 11;
	localparam int unsigned ADDR_W        = 64;
	localparam int unsigned UOP_MAX       = 4;
	localparam int unsigned ROM_DEPTH     = 16;
	localparam logic [5:0]  BLK32_MASK    = 6'h1F;
	localparam logic [11:0] PAGE4K_MASK   = 12'hFFF;
	localparam logic [15:0] PAGE64K_MASK  = 16'hFFFF;

	typedef enum logic [2:0] {
		MCS_OP_ALU   = 3'h0,
		MCS_OP_LOAD  = 3'h1,
		MCS_OP_STORE = 3'h2,
		MCS_OP_FLD   = 3'h3,
		MCS_OP_FST   = 3'h4,
		MCS_OP_HEAVY = 3'h5,
		MCS_OP_CPLX  = 3'h6
	} mcs_op_t;

	typedef struct packed {
		mcs_op_t           op;
		logic [3:0]        size;
		logic [ADDR_W-1:0] ea;
		logic              cinh;
		logic              byterev;
		logic              seg_cross;
		logic [3:0]        rom_idx;
	} mcs_instr_t;

	typedef struct packed {
		mcs_op_t    op;
		logic       dep_prev;
		logic       last;
		logic [3:0] size;
	} mcs_uword_t;

	typedef enum logic [1:0] {
		MCS_IDLE  = 2'b00,
		MCS_WAIT  = 2'b01,
		MCS_ISSUE = 2'b11
	} mcs_state_t;

endpackage

// *** src/mcs_rom.sv ***
// mcs_rom: microword storage, one sequence per entry index
// assumes synchronous read, one word per cycle
`timescale 1ns/10ps
module mcs_rom #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned SEQ   = 4
) (
	input  wire logic                 CLK,
	input  wire logic [3:0]           IDX,
	input  wire logic [1:0]           STEP,
	output mcs_pkg::mcs_uword_t       WORD
);
	import mcs_pkg::*;

	initial begin
		if (DEPTH > 16 || SEQ != 4)
			$error("mcs_rom: unsupported geometry");
	end

	mcs_uword_t rom [0:DEPTH*SEQ-1];
	mcs_uword_t word_q;

	// typical expansions: integer op then dependent load/store
	always_comb begin
		for (int i = 0; i < DEPTH*SEQ; i++) begin
			rom[i] = '{op: MCS_OP_ALU, dep_prev: 1'b0, last: 1'b0,
				size: 4'h0};
			if (i % SEQ == 1) begin
				rom[i].op = (i / SEQ) % 2 == 0 ? MCS_OP_LOAD : MCS_OP_STORE;
				rom[i].dep_prev = 1'b1;
				rom[i].size = 4'h8;
				rom[i].last = ((i / SEQ) % 4) < 2;
			end
			if (i % SEQ == 2) begin
				rom[i].dep_prev = 1'b1;
				rom[i].last = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK) begin
		word_q <= rom[{IDX, STEP}];
	end

	assign WORD = word_q;
endmodule

// *** dv/mcs_seq_asserts.sv ***
// mcs_seq_asserts: port checks for mcs_seq
// assumes bind to mcs_seq, one clock
`timescale 1ns/10ps
module mcs_seq_asserts #(
	parameter int unsigned ROM_WAIT = 11
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic IN_READY,
	input wire logic UOP_VALID,
	input wire logic ISSUE_READY,
	input wire logic ALIGN_INT,
	input wire logic MICROCODED_MARKER,
	input wire logic ASYNC_IRQ_REQ,
	input wire logic ASYNC_IRQ_TAKE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic [7:0] wait_q;
	// saturates, so long sequences never wrap; wide enough for ROM_WAIT 255
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N) wait_q <= 8'h00;
		else if (!MICROCODED_MARKER) wait_q <= 8'h00;
		else if (wait_q != 8'hFF) wait_q <= wait_q + 8'h01;
	////////////////////////////////////////////////////////////////
	rom_wait_a: assert property (
		UOP_VALID |-> wait_q >= ROM_WAIT - 1) else $error("early uop");
	uop_seq_a: assert property (
		UOP_VALID |-> MICROCODED_MARKER) else $error("uop outside");
	uop_gap_a: assert property (
		UOP_VALID && ISSUE_READY |=> !UOP_VALID) else $error("no gap");
	uop_hold_a: assert property (
		UOP_VALID && !ISSUE_READY |=> UOP_VALID) else $error("uop lost");
	irq_block_a: assert property (
		MICROCODED_MARKER |-> !ASYNC_IRQ_TAKE) else $error("irq taken");
	irq_pass_a: assert property (
		ASYNC_IRQ_REQ && !MICROCODED_MARKER |-> ASYNC_IRQ_TAKE)
		else $error("irq held");
	seq_atomic_a: assert property (
		MICROCODED_MARKER |-> !IN_READY) else $error("fetch mid seq");
	seq_end_a: assert property (
		$fell(MICROCODED_MARKER) |-> $past(UOP_VALID))
		else $error("bad end");
	align_pulse_a: assert property (
		ALIGN_INT |=> !ALIGN_INT) else $error("long align");
	cover property (ALIGN_INT);
	cover property ($fell(MICROCODED_MARKER));
	cover property (ASYNC_IRQ_REQ && MICROCODED_MARKER);
endmodule
bind mcs_seq mcs_seq_asserts #(.ROM_WAIT(ROM_WAIT)) u_chk (.CLK(CLK),
	.RST_N(RST_N), .IN_READY(IN_READY), .UOP_VALID(UOP_VALID),
	.ISSUE_READY(ISSUE_READY), .ALIGN_INT(ALIGN_INT),
	.MICROCODED_MARKER(MICROCODED_MARKER),
	.ASYNC_IRQ_REQ(ASYNC_IRQ_REQ), .ASYNC_IRQ_TAKE(ASYNC_IRQ_TAKE));

// *** dv/mcs_issue_model.sv ***
// mcs_issue_model: issue stage stand-in
// assumes SLOW makes readiness alternate; results come 3 cycles late
`timescale 1ns/10ps
module mcs_issue_model (
	input  wire logic CLK,
	input  wire logic SLOW,
	input  wire logic UOP_VALID,
	output logic      ISSUE_READY,
	output logic      DEP_DONE
);
	logic [1:0] lat_q = 2'h0;
	initial ISSUE_READY = 1'h1;
	assign DEP_DONE = lat_q == 2'h1;
	always @(posedge CLK) begin
		ISSUE_READY <= SLOW ? ~ISSUE_READY : 1'h1;
		if (UOP_VALID && ISSUE_READY) lat_q <= 2'h3;
		else if (lat_q != 2'h0) lat_q <= lat_q - 2'h1;
	end
endmodule

// *** dv/mcs_seq_bench.sv ***
// mcs_seq_bench: directed scenarios for mcs_seq
// assumes mcs_pkg and the issue model compiled first
`timescale 1ns/10ps
module mcs_seq_bench;
	import mcs_pkg::*;
	logic clk = 0, rst_n = 0, in_valid = 0, irq = 0, slow = 0;
	logic in_ready, dv, uv, ci, rdy, dep, al, mk_o, take;
	mcs_instr_t in_instr = '0;
	mcs_uword_t uw;
	mcs_instr_t di;
	int errors = 0, compares = 0;
	always #2 clk = ~clk;
	mcs_seq dut (.CLK(clk), .RST_N(rst_n), .IN_VALID(in_valid),
		.IN_INSTR(in_instr), .IN_READY(in_ready), .DIRECT_VALID(dv),
		.DIRECT_INSTR(di), .UOP_VALID(uv), .UOP_WORD(uw),
		.UOP_CI_ALIGN(ci), .ISSUE_READY(rdy), .DEP_DONE(dep),
		.ALIGN_INT(al), .MICROCODED_MARKER(mk_o),
		.ASYNC_IRQ_REQ(irq), .ASYNC_IRQ_TAKE(take));
	mcs_issue_model model (.CLK(clk), .SLOW(slow), .UOP_VALID(uv),
		.ISSUE_READY(rdy), .DEP_DONE(dep));
	////////////////////////////////////////////////////////////////
	task automatic chk(logic [3:0] seen, logic [3:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// flg: idx2, cinh, byterev, seg_cross
	function automatic mcs_instr_t mk(mcs_op_t op, logic [3:0] sz,
		logic [15:0] ea, logic [3:0] flg);
		mk = '0;
		mk.op = op;
		mk.size = sz;
		mk.ea = {48'h0, ea};
		{mk.cinh, mk.byterev, mk.seg_cross} = flg[2:0];
		mk.rom_idx = {2'h0, flg[3], 1'h0};
	endfunction
	// e: marker, align, direct one-hot; w: words expected
	task automatic go(mcs_instr_t i, logic [3:0] e, logic [3:0] w);
		int n;
		logic dd;
		@(posedge clk);
		in_valid <= 1'h1;
		in_instr <= i;
		do @(negedge clk); while (!in_ready);
		@(posedge clk);
		in_valid <= 1'h0;
		@(negedge clk);
		chk({1'h0, mk_o, al, dv}, e);
		chk({1'h0, di.op}, {1'h0, i.op});
		chk(di.size, i.size);
		n = 1;
		dd = 0;
		while (mk_o && !uv) begin
			@(negedge clk);
			n++;
		end
		if (mk_o) chk(n >= 11, 4'h1);
		n = 0;
		while (mk_o) begin
			chk(take, 4'h0);
			dd |= dep;
			if (uv && rdy) begin
				n++;
				if (uw.dep_prev) chk(dd, 4'h1);
				chk(ci, i.cinh && uw.op != MCS_OP_ALU);
				dd = 0;
			end
			@(negedge clk);
		end
		chk(n[3:0], w);
		chk(take, irq);
		while (dv) @(negedge clk);
	endtask
	task automatic t_direct;
		go(mk(MCS_OP_LOAD, 4'h8, 16'h0008, 4'h0), 4'h1, 4'h0);
		go(mk(MCS_OP_LOAD, 4'h8, 16'h0008, 4'h2), 4'h1, 4'h0);
		go(mk(MCS_OP_STORE, 4'h4, 16'h001E, 4'h0), 4'h4, 4'h2);
	endtask
	task automatic t_cross;
		go(mk(MCS_OP_LOAD, 4'h4, 16'h0FFE, 4'h0), 4'h4, 4'h2);
		go(mk(MCS_OP_LOAD, 4'h8, 16'h0010, 4'h1), 4'h4, 4'h2);
		go(mk(MCS_OP_LOAD, 4'h2, 16'hFFFF, 4'h0), 4'h4, 4'h2);
		go(mk(MCS_OP_LOAD, 4'h8, 16'h003C, 4'h2), 4'h4, 4'h2);
	endtask
	task automatic t_align;
		go(mk(MCS_OP_FLD, 4'h4, 16'h0002, 4'h0), 4'h2, 4'h0);
		go(mk(MCS_OP_FST, 4'h8, 16'h001C, 4'h0), 4'h4, 4'h2);
		go(mk(MCS_OP_LOAD, 4'h4, 16'h0004, 4'h4), 4'h1, 4'h0);
		go(mk(MCS_OP_STORE, 4'h4, 16'h0006, 4'h4), 4'h2, 4'h0);
		go(mk(MCS_OP_LOAD, 4'h3, 16'h0000, 4'h4), 4'h2, 4'h0);
	endtask
	task automatic t_heavy;
		@(posedge clk);
		slow <= 1'h1;
		go(mk(MCS_OP_HEAVY, 4'h4, 16'h0003, 4'h0), 4'h4, 4'h2);
		go(mk(MCS_OP_CPLX, 4'h4, 16'h0000, 4'hC), 4'h4, 4'h3);
		@(posedge clk);
		irq <= 1'h1;
		go(mk(MCS_OP_HEAVY, 4'h8, 16'h0000, 4'h0), 4'h4, 4'h2);
		@(posedge clk);
		irq <= 1'h0;
		slow <= 1'h0;
	endtask
	task automatic final_report;
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// whole run needs well under 2000 cycles
	initial begin
		#20000;
		errors++;
		final_report;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		t_direct;
		t_cross;
		t_align;
		t_heavy;
		final_report;
	end
endmodule
